// ---- design/reset_seq_pkg.sv ----
package reset_seq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and reference period
	localparam int unsigned CLK_PERIOD_NS     = 5;
	// Reference oscillator period; board dependent, plain default
	localparam int unsigned REF_PERIOD_NS     = 40;
	// A reference period rounds up to whole clk cycles
	localparam int unsigned REF_DIV_CYC       = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Release delays and pulse widths, in reference periods
	localparam int unsigned SAFETY_COLD_PER   = 6120;
	localparam int unsigned MAIN_COLD_PER     = 9195;
	localparam int unsigned SAFETY_WARM_PER   = 966;
	localparam int unsigned MAIN_WARM_PER     = 4040;

	////////////////////////////////////////////////////////////////////////
	// Assertion delays
	localparam int unsigned WARM_TO_MAIN_NS   = 960;
	localparam int unsigned WARM_TO_MAIN_CYC  = WARM_TO_MAIN_NS / CLK_PERIOD_NS;
	localparam int unsigned REQ_ISO_MULT      = 900;

	////////////////////////////////////////////////////////////////////////
	// External party minimum low times, not enforced here
	localparam int unsigned COLD_XTAL_MIN_NS  = 9500000;
	localparam int unsigned PIN_LOW_MIN_NS    = 1200;

	////////////////////////////////////////////////////////////////////////
	// Widths and reset values
	localparam int unsigned PER_W             = 16;
	localparam int unsigned ISO_W             = 16;
	localparam int unsigned REQ_CNT_W         = 26;
	// Cold pin reads low, warm and request read high, so reset acts as a cold reset
	localparam logic [2:0]  PIN_RESET_VAL     = 3'h3;

	typedef struct packed {
		logic cold_reset_in_n;
		logic safety_warm_reset_in_n;
		logic main_reset_request_in_n;
	} pin_in_t;

	typedef struct packed {
		logic sw_safety_warm_reset;
		logic sw_main_cold_reset;
		logic sw_main_warm_reset;
	} sw_reset_t;

endpackage

// ---- design/reset_status_sequencer.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - Cold low asserts safety status at once; release 6120 reference periods later.
// - Cold low asserts main status at once; release 9195 reference periods later.
// - Software safety warm reset holds safety status low 966 reference periods.
// - Any software reset holds main status low at least 4040 reference periods.
// - Safety warm low asserts safety status; release 966 reference periods after rise.
// - Safety warm low asserts main status 960 ns later; release after 4040 periods.
// - Request low asserts main status after 900 times isolation time; release 4040 periods.
module reset_status_sequencer
	import reset_seq_pkg::*;
#(
	parameter int unsigned REF_DIV     = REF_DIV_CYC,
	parameter int unsigned SAFETY_COLD = SAFETY_COLD_PER,
	parameter int unsigned MAIN_COLD   = MAIN_COLD_PER,
	parameter int unsigned SAFETY_WARM = SAFETY_WARM_PER,
	parameter int unsigned MAIN_WARM   = MAIN_WARM_PER,
	parameter int unsigned WARM_DLY    = WARM_TO_MAIN_CYC
)
(
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// Reset pins from the board
	input  wire reset_seq_pkg::pin_in_t       pins,
	// Software reset pulses, same clock
	input  wire reset_seq_pkg::sw_reset_t     sw_rst,
	// Reset isolation time in clk cycles
	input  wire logic [reset_seq_pkg::ISO_W-1:0] iso_time,
	// Reset status outputs
	output logic                              safety_reset_status_n,
	output logic                              main_reset_status_n
);
	import reset_seq_pkg::*;

	if (REF_DIV < 1 || REF_DIV > 255 || SAFETY_COLD < 1 || MAIN_COLD < 1 || SAFETY_WARM < 1 || MAIN_WARM < 1
		|| SAFETY_COLD >= 65535 || MAIN_COLD >= 65535 || SAFETY_WARM >= 65535 || MAIN_WARM >= 65535
		|| WARM_DLY < 1 || WARM_DLY > 255)
	begin : g_bad_param
		$error("reset_status_sequencer: parameter out of range");
	end

	localparam logic [PER_W-1:0] SAFETY_COLD_T = PER_W'(SAFETY_COLD);
	localparam logic [PER_W-1:0] MAIN_COLD_T   = PER_W'(MAIN_COLD);
	localparam logic [PER_W-1:0] SAFETY_WARM_T = PER_W'(SAFETY_WARM);
	localparam logic [PER_W-1:0] MAIN_WARM_T   = PER_W'(MAIN_WARM);
	localparam logic [7:0]       REF_LAST      = 8'(REF_DIV - 1);
	localparam logic [7:0]       WARM_DLY_T    = 8'(WARM_DLY);
	localparam logic [9:0]       ISO_MULT_T    = 10'(REQ_ISO_MULT);

	// Pick the release target: cold wins, a pending longer release is kept
	function automatic logic [PER_W-1:0] pick_target(
		input logic             cold,
		input logic             busy,
		input logic [PER_W-1:0] cur,
		input logic [PER_W-1:0] cold_val,
		input logic [PER_W-1:0] warm_val
	);
		logic [PER_W-1:0] t;
		t = warm_val;
		if (cold)
			t = cold_val;
		else if (busy && cur > warm_val)
			t = cur;
		return t;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; a change counts once stages two and three agree
	logic [2:0] sync1_r;
	logic [2:0] sync2_r;
	logic [2:0] sync3_r;
	logic [2:0] pin_lvl_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_r <= PIN_RESET_VAL;
			sync2_r <= PIN_RESET_VAL;
			sync3_r <= PIN_RESET_VAL;
		end
		else
		begin
			sync1_r <= pins;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pin_lvl_r <= PIN_RESET_VAL;
		else
			for (int i = 0; i < 3; i++)
				if (sync2_r[i] == sync3_r[i])
					pin_lvl_r[i] <= sync3_r[i];
	end

	pin_in_t lvl;
	assign lvl = pin_in_t'(pin_lvl_r);

	logic cold_act;
	logic warm_act;
	logic req_act;
	assign cold_act = ~lvl.cold_reset_in_n;
	assign warm_act = ~lvl.safety_warm_reset_in_n;
	assign req_act  = ~lvl.main_reset_request_in_n;

	////////////////////////////////////////////////////////////////////////
	// Reference period tick
	logic [7:0] div_r;
	logic       ref_tick_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			div_r      <= 8'h00;
			ref_tick_r <= 1'b0;
		end
		else
		begin
			ref_tick_r <= (div_r == REF_LAST);
			div_r      <= (div_r == REF_LAST) ? 8'h00 : div_r + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Delayed assertion of main status from warm pin and request pin
	logic [7:0]           warm_dly_r;
	logic [REQ_CNT_W-1:0] req_dly_r;
	logic [REQ_CNT_W-1:0] req_target;

	assign req_target = ISO_MULT_T * iso_time;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			warm_dly_r <= 8'h00;
		else if (!warm_act)
			warm_dly_r <= 8'h00;
		else if (warm_dly_r != WARM_DLY_T)
			warm_dly_r <= warm_dly_r + 8'h01;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			req_dly_r <= '0;
		else if (!req_act)
			req_dly_r <= '0;
		else if (req_dly_r < req_target)
			req_dly_r <= req_dly_r + REQ_CNT_W'(1);
	end

	logic warm_main;
	logic req_main;
	assign warm_main = warm_act && (warm_dly_r == WARM_DLY_T);
	assign req_main  = req_act && (req_dly_r >= req_target);

	////////////////////////////////////////////////////////////////////////
	// Hold conditions
	logic safety_hold;
	logic main_hold;
	assign safety_hold = cold_act | warm_act | sw_rst.sw_safety_warm_reset;
	assign main_hold   = cold_act | warm_main | req_main | sw_rst.sw_safety_warm_reset
		| sw_rst.sw_main_cold_reset | sw_rst.sw_main_warm_reset;

	////////////////////////////////////////////////////////////////////////
	// Safety domain release counter
	logic [PER_W-1:0] safety_cnt_r;
	logic [PER_W-1:0] safety_tgt_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			safety_tgt_r <= SAFETY_COLD_T;
		else if (safety_hold)
			safety_tgt_r <= pick_target(cold_act, ~safety_reset_status_n, safety_tgt_r,
				SAFETY_COLD_T, SAFETY_WARM_T);
	end

	// One extra tick: the first tick after release may come early in its period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			safety_cnt_r <= '0;
		else if (safety_hold)
			safety_cnt_r <= '0;
		else if (ref_tick_r && safety_cnt_r <= safety_tgt_r)
			safety_cnt_r <= safety_cnt_r + PER_W'(1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			safety_reset_status_n <= 1'b0;
		else if (safety_hold)
			safety_reset_status_n <= 1'b0;
		else if (safety_cnt_r > safety_tgt_r)
			safety_reset_status_n <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Main domain release counter
	logic [PER_W-1:0] main_cnt_r;
	logic [PER_W-1:0] main_tgt_r;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			main_tgt_r <= MAIN_COLD_T;
		else if (main_hold)
			main_tgt_r <= pick_target(cold_act, ~main_reset_status_n, main_tgt_r,
				MAIN_COLD_T, MAIN_WARM_T);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			main_cnt_r <= '0;
		else if (main_hold)
			main_cnt_r <= '0;
		else if (ref_tick_r && main_cnt_r <= main_tgt_r)
			main_cnt_r <= main_cnt_r + PER_W'(1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			main_reset_status_n <= 1'b0;
		else if (main_hold)
			main_reset_status_n <= 1'b0;
		else if (main_cnt_r > main_tgt_r)
			main_reset_status_n <= 1'b1;
	end

endmodule // reset_status_sequencer

// ---- dv/board_model.sv ----
`timescale 1ns/100ps
module board_model
	import reset_seq_pkg::*;
#(
	parameter int unsigned LOW_CYC = 240,
	parameter int unsigned PWR_CYC = 240
)
(
	// Clock
	input  wire logic                    clk,
	// One pulse request per pin
	input  wire logic [2:0]              go,
	// Pins toward the device
	output reset_seq_pkg::pin_in_t       pins
);
	int unsigned cnt [3] = '{0, 0, PWR_CYC};
	// Crystal hold shortened by PWR_CYC; real board waits far longer
	// Rails not modelled; always-on rails stay up, so pins keep their levels
	always @(posedge clk)
		for (int i = 0; i < 3; i++)
			cnt[i] <= go[i] ? LOW_CYC : (cnt[i] != 0 ? cnt[i] - 1 : 0);
	assign pins = pin_in_t'({cnt[2] == 0, cnt[1] == 0, cnt[0] == 0});
endmodule // board_model

// ---- dv/reset_seq_asserts.sv ----
`timescale 1ns/100ps
module reset_seq_checker
	import reset_seq_pkg::*;
#(
	parameter int unsigned REF_DIV     = 1,
	parameter int unsigned SAFETY_COLD = 6,
	parameter int unsigned MAIN_COLD   = 9,
	parameter int unsigned SAFETY_WARM = 3,
	parameter int unsigned MAIN_WARM   = 4
)
(
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      rst,
	// Watched ports
	input wire reset_seq_pkg::pin_in_t    pins,
	input wire reset_seq_pkg::sw_reset_t  sw_rst,
	input wire logic                      safety_reset_status_n,
	input wire logic                      main_reset_status_n
);
	logic [15:0] cold_hi_r;
	logic [15:0] warm_hi_r;
	logic [15:0] req_hi_r;
	////////////////////////////////////////////////////////////////////////
	// Saturating, so long idle runs never wrap
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			cold_hi_r <= '0;
			warm_hi_r <= '0;
			req_hi_r <= '0;
		end
		else
		begin
			cold_hi_r <= pins.cold_reset_in_n ? cold_hi_r + {15'h0, ~&cold_hi_r} : '0;
			warm_hi_r <= pins.safety_warm_reset_in_n ? warm_hi_r + {15'h0, ~&warm_hi_r} : '0;
			req_hi_r <= pins.main_reset_request_in_n ? req_hi_r + {15'h0, ~&req_hi_r} : '0;
		end
	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence warm_held;
		$fell(pins.safety_warm_reset_in_n) ##1 !pins.safety_warm_reset_in_n [*8];
	endsequence
	AST_COLD_SAFE: assert property ($fell(pins.cold_reset_in_n) |-> ##[1:6] !safety_reset_status_n)
		else $error("safety status missed cold reset");
	AST_COLD_MAIN: assert property ($fell(pins.cold_reset_in_n) |-> ##[1:6] !main_reset_status_n)
		else $error("main status missed cold reset");
	AST_SAFE_COLD_REL: assert property ($rose(safety_reset_status_n) |-> cold_hi_r > SAFETY_COLD * REF_DIV)
		else $error("safety status released early after cold");
	AST_MAIN_COLD_REL: assert property ($rose(main_reset_status_n) |-> cold_hi_r > MAIN_COLD * REF_DIV)
		else $error("main status released early after cold");
	AST_WARM_SAFE: assert property ($fell(pins.safety_warm_reset_in_n) |-> ##[1:6] !safety_reset_status_n)
		else $error("safety status missed warm reset");
	AST_WARM_MAIN: assert property (warm_held |-> !main_reset_status_n)
		else $error("main status missed warm reset");
	AST_SAFE_WARM_REL: assert property ($rose(safety_reset_status_n) |-> warm_hi_r > SAFETY_WARM * REF_DIV)
		else $error("safety status released early after warm");
	AST_MAIN_REL: assert property ($rose(main_reset_status_n) |-> (warm_hi_r > MAIN_WARM * REF_DIV)
		&& (req_hi_r > MAIN_WARM * REF_DIV))
		else $error("main status released early after warm or request");
	AST_SW_SAFE: assert property (sw_rst.sw_safety_warm_reset |=> !safety_reset_status_n [*3])
		else $error("safety status pulse too short");
	AST_SW_MAIN: assert property ((|sw_rst) |=> !main_reset_status_n [*4])
		else $error("main status pulse too short");
endmodule // reset_seq_checker

bind reset_status_sequencer reset_seq_checker #(.REF_DIV(REF_DIV), .SAFETY_COLD(SAFETY_COLD), .MAIN_COLD(MAIN_COLD),
	.SAFETY_WARM(SAFETY_WARM), .MAIN_WARM(MAIN_WARM)) reset_seq_checker_inst (.clk(clk), .rst(rst), .pins(pins),
	.sw_rst(sw_rst), .safety_reset_status_n(safety_reset_status_n), .main_reset_status_n(main_reset_status_n));

// ---- dv/tb.sv ----
`timescale 1ns/100ps
module tb;
	import reset_seq_pkg::*;
	localparam int unsigned SC = 6, MC = 9, SW = 3, MW = 4;
	logic      clk = 0;
	logic      rst = 1;
	logic [2:0] go = '0;
	sw_reset_t sw_rst = '0;
	logic [ISO_W-1:0] iso_time = 16'h0001;
	pin_in_t   pins;
	logic      safe_n;
	logic      main_n;
	int        error_cnt = 0;
	int        total_checks = 0;
	int        cyc = 0;
	always #2.5 clk = ~clk;
	board_model #(.LOW_CYC(1000)) board_model_inst (.clk(clk), .go(go), .pins(pins));
	reset_status_sequencer #(.REF_DIV(1), .SAFETY_COLD(SC), .MAIN_COLD(MC), .SAFETY_WARM(SW), .MAIN_WARM(MW),
		.WARM_DLY(2)) reset_status_sequencer_inst (.clk(clk), .rst(rst), .pins(pins), .sw_rst(sw_rst),
		.iso_time(iso_time), .safety_reset_status_n(safe_n), .main_reset_status_n(main_n));
	////////////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Ceiling well above the few thousand cycles the run needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			give_verdict();
		end
	end
	task pulse(input int i);
		go[i] = 1'b1;
		@(negedge clk);
		go[i] = 1'b0;
	endtask
	task wait_pin(input int i);
		while (pins[i] !== 1'b1)
			@(negedge clk);
	endtask
	// Cycles from here until each status rises; ts 0 skips safety
	task rel(input int ts, input int tm, input int lo);
		int n, ns, nm;
		n = 0;
		ns = 0;
		nm = 0;
		while ((safe_n !== 1'b1 || main_n !== 1'b1) && n < 20000)
		begin
			@(negedge clk);
			n++;
			if (safe_n === 1'b1 && ns == 0)
				ns = n;
			if (main_n === 1'b1 && nm == 0)
				nm = n;
		end
		if (ts != 0)
			check(ns >= ts + lo && ns <= ts + 7, 1'b1);
		check(nm >= tm + lo && nm <= tm + 7, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_cold(input bit fire);
		if (fire)
		begin
			pulse(2);
			repeat (6) @(negedge clk);
		end
		check({safe_n, main_n}, 2'h0);
		wait_pin(2);
		rel(SC, MC, 6);
	endtask
	task t_warm;
		pulse(1);
		repeat (5) @(negedge clk);
		check({safe_n, main_n}, 2'h1);
		repeat (2) @(negedge clk);
		check(main_n, 1'b0);
		wait_pin(1);
		rel(SW, MW, 6);
	endtask
	task t_req;
		pulse(0);
		repeat (900) @(negedge clk);
		check({safe_n, main_n}, 2'h3);
		repeat (10) @(negedge clk);
		check(main_n, 1'b0);
		wait_pin(0);
		rel(0, MW, 6);
	endtask
	task t_sw;
		for (int i = 0; i < 3; i++)
		begin
			sw_rst = sw_reset_t'(3'h1 << i);
			@(negedge clk);
			sw_rst = '0;
			check({safe_n, main_n}, {i != 2, 1'b0});
			rel(i == 2 ? SW : 0, MW, 0);
		end
	endtask
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		t_cold(1'b0);
		t_cold(1'b1);
		t_warm();
		t_req();
		t_sw();
		give_verdict();
	end
endmodule // tb
